//--- design/eil_loader.sv
// Power-on identity loader reading a serial EEPROM over a two-wire bus
//
// Functional notes
// - Fetch vendor, product and configuration bytes from external EEPROM.
// - Only pull clock and data low or release them; never drive high.
// - Bus is idle only while data and clock are both high.
// - Start: data falls while clock stays high.
// - Stop: data rises while clock stays high.
// - Data changes only while clock is low, outside start and stop.
// - Every transfer opens with start and closes with stop.
// - A new transfer begins only when the bus is seen idle.
// - Receiver acknowledges each byte by holding data low on ninth pulse; loader leaves the last byte read unacknowledged.
// - Target address is always seven bits 1010 000b.
// - No page-select addressing; low three target address bits stay zero.
// - Without EEPROM, built-in default identifiers are supplied.
`include "eil_defs.svh"
`default_nettype none
module eil_loader #(
  parameter int unsigned      IDLE_CNT = `EIL_IDLE_CNT,
  // Built-in identifiers, values arbitrary
  parameter eil_pkg::eil_id_t DEF_ID   = '{
    vendor:     `EIL_DEF_VENDOR,
    device:     `EIL_DEF_DEVICE,
    sub_vendor: `EIL_DEF_SUB_VENDOR,
    sub_device: `EIL_DEF_SUB_DEVICE,
    cfg:        `EIL_DEF_CFG
  }
) (
  input  wire logic            clock,
  input  wire logic            rst_b,
  input  wire logic            link_clk,
  input  wire logic            scl_in,
  output logic                 scl_out,
  output logic                 scl_oe,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  output eil_pkg::eil_id_t     id,
  output logic                 load_done,
  output logic                 eeprom_found
);

  localparam int unsigned NBYTES = `EIL_NBYTES;
  localparam int unsigned PHW    = `EIL_PH_BITS;
  localparam int unsigned IDXW   = $clog2(NBYTES);
  localparam int unsigned CNTW   = $clog2(IDLE_CNT + 1);
  localparam logic [IDXW-1:0] LAST_IDX = IDXW'(NBYTES - 1);
  localparam logic [CNTW-1:0] IDLE_END = CNTW'(IDLE_CNT - 1);

  // Quarters of one bit time on the link
  localparam logic [1:0] QTR_HOLD = 2'h0;
  localparam logic [1:0] QTR_SET  = 2'h1;
  localparam logic [1:0] QTR_HI0  = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Byte assembly: identifiers are stored low byte first

  function automatic eil_pkg::eil_id_t build_id(
    input logic [7:0] b [NBYTES]
  );
    eil_pkg::eil_id_t r;
    r.vendor     = {b[1], b[0]};
    r.device     = {b[3], b[2]};
    r.sub_vendor = {b[5], b[4]};
    r.sub_device = {b[7], b[6]};
    r.cfg        = b[8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main clock domain: launch once, collect result once

  logic start_req_r;
  logic done_s;
  logic load_done_r;
  logic found_q_r;
  eil_pkg::eil_id_t id_r;

  // Link-domain results, quasi-static once done is seen
  logic [7:0] mem [NBYTES];
  logic       found_r;
  logic       done_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_req_r <= 1'b0;
    end else begin
      start_req_r <= 1'b1;
    end
  end

  eil_sync #(.W(1)) u_done_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (done_r),
    .q     (done_s)
  );

  // Capture is safe: link side froze mem and found before raising done
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      id_r        <= DEF_ID;
      found_q_r   <= 1'b0;
      load_done_r <= 1'b0;
    end else if (done_s && !load_done_r) begin
      id_r        <= found_r ? build_id(mem) : DEF_ID;
      found_q_r   <= found_r;
      load_done_r <= 1'b1;
    end
  end

  assign id           = id_r;
  assign load_done    = load_done_r;
  assign eeprom_found = found_q_r;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: pin and request synchronisers

  logic [1:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       start_s;
  logic       bus_idle;

  eil_sync #(.W(2)) u_pin_sync (
    .clock (link_clk),
    .rst_b (rst_b),
    .d     ({scl_in, sda_in}),
    .q     (pin_s)
  );

  eil_sync #(.W(1)) u_start_sync (
    .clock (link_clk),
    .rst_b (rst_b),
    .d     (start_req_r),
    .q     (start_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // free only when both lines high
  assign bus_idle = scl_s & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: sequencer

  eil_pkg::eil_state_t state_r;
  logic [PHW-1:0]      ph_r;
  logic [1:0]          qtr;
  logic                bit_end;
  logic [3:0]          bit_r;
  logic [1:0]          seq_r;
  logic [7:0]          shift_r;
  logic [IDXW-1:0]     idx_r;
  logic [CNTW-1:0]     idle_cnt_r;
  logic                active;
  logic                ack_slot;

  assign qtr      = ph_r[PHW-1:PHW-2];
  assign bit_end  = &ph_r;
  assign ack_slot = (bit_r == `EIL_ACK_BIT);
  assign active   = (state_r == eil_pkg::EIL_START) ||
                    (state_r == eil_pkg::EIL_TX)    ||
                    (state_r == eil_pkg::EIL_RX)    ||
                    (state_r == eil_pkg::EIL_STOP);

  // Phase counter restarts at zero on entry to every bit
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r <= '0;
    end else if (active) begin
      ph_r <= ph_r + 1'b1;
    end else begin
      ph_r <= '0;
    end
  end

  // require a run of free-bus cycles
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_r <= '0;
    end else if (state_r != eil_pkg::EIL_WAIT || !bus_idle) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != IDLE_END) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= eil_pkg::EIL_HOLD;
      bit_r   <= '0;
      seq_r   <= '0;
      shift_r <= '0;
      idx_r   <= '0;
      found_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      case (state_r)
        eil_pkg::EIL_HOLD: begin
          if (start_s) begin
            state_r <= eil_pkg::EIL_WAIT;
          end
        end
        eil_pkg::EIL_WAIT: begin
          if (bus_idle && idle_cnt_r == IDLE_END) begin
            // page bits are zero in the constant
            shift_r <= {`EIL_TARGET_ADDR, `EIL_WR_BIT};
            seq_r   <= 2'h0;
            state_r <= eil_pkg::EIL_START;
          end
        end
        eil_pkg::EIL_START: begin
          if (bit_end) begin
            bit_r   <= '0;
            state_r <= eil_pkg::EIL_TX;
          end
        end
        eil_pkg::EIL_TX: begin
          if (bit_end) begin
            if (!ack_slot) begin
              shift_r <= {shift_r[6:0], 1'b0};
              bit_r   <= bit_r + 1'b1;
            end else if (sda_s) begin
              state_r <= eil_pkg::EIL_STOP;
            end else begin
              bit_r <= '0;
              case (seq_r)
                2'h0: begin
                  shift_r <= `EIL_WORD_ADDR;
                  seq_r   <= 2'h1;
                end
                2'h1: begin
                  shift_r <= {`EIL_TARGET_ADDR, `EIL_RD_BIT};
                  seq_r   <= 2'h2;
                  state_r <= eil_pkg::EIL_START;
                end
                default: begin
                  idx_r   <= '0;
                  seq_r   <= 2'h3;
                  state_r <= eil_pkg::EIL_RX;
                end
              endcase
            end
          end
        end
        eil_pkg::EIL_RX: begin
          if (bit_end) begin
            if (!ack_slot) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= bit_r + 1'b1;
            end else begin
              bit_r <= '0;
              idx_r <= idx_r + 1'b1;
              if (idx_r == LAST_IDX) begin
                found_r <= 1'b1;
                state_r <= eil_pkg::EIL_STOP;
              end
            end
          end
        end
        eil_pkg::EIL_STOP: begin
          if (bit_end) begin
            done_r  <= 1'b1;
            state_r <= eil_pkg::EIL_DONE;
          end
        end
        eil_pkg::EIL_DONE: begin
          state_r <= eil_pkg::EIL_DONE;
        end
        default: begin
          state_r <= eil_pkg::EIL_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (state_r == eil_pkg::EIL_RX && bit_end && ack_slot) begin
      mem[idx_r] <= shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: line drivers
  // Both drives are registered, so every edge seen at the pins lags the
  // phase counter by one cycle; the sample at the end of a bit therefore
  // sees the line from the middle of the clock-high half.

  logic scl_low_r;
  logic sda_low_r;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_low_r <= 1'b0;
    end else begin
      case (state_r)
        eil_pkg::EIL_START: begin
          scl_low_r <= (qtr == QTR_HOLD);
        end
        eil_pkg::EIL_TX,
        eil_pkg::EIL_RX,
        eil_pkg::EIL_STOP: begin
          scl_low_r <= (qtr < QTR_HI0);
        end
        default: begin
          scl_low_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_low_r <= 1'b0;
    end else begin
      case (state_r)
        eil_pkg::EIL_START: begin
          sda_low_r <= (qtr >= QTR_HI0);
        end
        eil_pkg::EIL_TX: begin
          // change only in the low half
          if (qtr == QTR_SET) begin
            sda_low_r <= !ack_slot && !shift_r[7];
          end
        end
        eil_pkg::EIL_RX: begin
          if (qtr == QTR_SET) begin
            sda_low_r <= ack_slot && (idx_r != LAST_IDX);
          end
        end
        eil_pkg::EIL_STOP: begin
          if (qtr != QTR_HOLD) begin
            sda_low_r <= (qtr != 2'h3);
          end
        end
        default: begin
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  // open drain: drive low or release
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_low_r;
  assign sda_oe  = sda_low_r;

endmodule
`default_nettype wire

//--- pkg/eil_defs.svh
// Constants for the serial EEPROM identity loader
`ifndef EIL_DEFS_SVH
`define EIL_DEFS_SVH

// Fixed target address, page-select bits held at zero
`define EIL_TARGET_ADDR 7'h50
`define EIL_RD_BIT      1'b1
`define EIL_WR_BIT      1'b0
// First EEPROM byte read
`define EIL_WORD_ADDR   8'h00
// Bytes read: four 16-bit identifiers, then one configuration byte
`define EIL_NBYTES      9
// Link cycles the bus must stay free before a transfer starts
`define EIL_IDLE_CNT    16
// Bits of the per-bit phase counter (16 link cycles per bit)
`define EIL_PH_BITS     4
// Bit index of the acknowledge slot
`define EIL_ACK_BIT     4'h8

// Built-in identifiers (values arbitrary)
`define EIL_DEF_VENDOR     16'h1234
`define EIL_DEF_DEVICE     16'h5678
`define EIL_DEF_SUB_VENDOR 16'h1234
`define EIL_DEF_SUB_DEVICE 16'h0001
`define EIL_DEF_CFG        8'h00

`endif

//--- pkg/eil_pkg.sv
// Types shared by the serial EEPROM identity loader
`default_nettype none
package eil_pkg;

  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] device;
    logic [15:0] sub_vendor;
    logic [15:0] sub_device;
    logic [7:0]  cfg;
  } eil_id_t;

  typedef enum logic [2:0] {
    EIL_HOLD,
    EIL_WAIT,
    EIL_START,
    EIL_TX,
    EIL_RX,
    EIL_STOP,
    EIL_DONE
  } eil_state_t;

endpackage
`default_nettype wire

//--- design/eil_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`default_nettype none
module eil_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- bench/eil_eeprom_model.sv
// Behavioural serial EEPROM on the two-wire bus
`default_nettype none
module eil_eeprom_model (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        present,
  input  wire logic [71:0] image,
  output logic             pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt = 0;
  int         ptr = 0;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  initial pull = 1'b0;
  always @(negedge sda) if (scl) begin
    cnt = -1;
    first = 1'b1;
    rd = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    rd = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (sda) rd = 1'b0;
  end
  // only pull low, only with clock low
  always @(negedge scl) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      if (first) begin
        pull = present && (sh[7:1] == 7'h50);
        rd = pull && sh[0];
        if (!sh[0]) ptr = 0;
        first = 1'b0;
      end else begin
        pull = !rd && present;
      end
    end else if (cnt == 9) begin
      cnt = 0;
      pull = 1'b0;
      if (rd) begin
        tx = image[71 - 8 * ptr -: 8];
        ptr = ptr + 1;
        pull = !tx[7];
      end
    end else if (rd && cnt > 0) begin
      pull = !tx[7 - cnt];
    end
  end
endmodule
`default_nettype wire

//--- bench/eil_loader_assertions.sv
// Wire and output checks for the identity loader
`default_nettype none
module eil_loader_assertions #(
  parameter eil_pkg::eil_id_t DEF_ID = '0
) (
  input wire logic             clock,
  input wire logic             rst_b,
  input wire logic             link_clk,
  input wire logic             scl_in,
  input wire logic             scl_out,
  input wire logic             scl_oe,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  input wire eil_pkg::eil_id_t id,
  input wire logic             load_done,
  input wire logic             eeprom_found
);
  property p_od;
    @(posedge clock) disable iff (!rst_b) !scl_out && !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("pin value not low");
  property p_idle;
    @(posedge link_clk) disable iff (!rst_b) $rose(sda_oe) && !scl_oe
      |-> $past(sda_in, 2) && $past(scl_in, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("start on busy bus");
  property p_start;
    @(posedge link_clk) disable iff (!rst_b) $rose(sda_oe) && !scl_oe
      |-> !scl_oe [*8] ##1 scl_oe;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_stop;
    @(posedge link_clk) disable iff (!rst_b)
      $fell(sda_oe) && !scl_oe && !$past(scl_oe)
      |-> !$past(scl_oe, 3) ##1 !scl_oe [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop");
  property p_data;
    @(posedge link_clk) disable iff (!rst_b)
      $changed(sda_oe) && scl_oe |-> $past(scl_oe, 3);
  endproperty
  a_data: assert property (p_data) else $error("data moved early");
  property p_quiet;
    @(posedge clock) disable iff (!rst_b)
      load_done |-> !scl_oe && !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus not free");
  property p_hold;
    @(posedge clock) disable iff (!rst_b)
      load_done |=> load_done && $stable(id) && $stable(eeprom_found);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_def;
    @(posedge clock) disable iff (!rst_b) !load_done |-> id == DEF_ID;
  endproperty
  a_def: assert property (p_def) else $error("id not default");
  property p_absent;
    @(posedge clock) disable iff (!rst_b)
      load_done && !eeprom_found |-> id == DEF_ID;
  endproperty
  a_absent: assert property (p_absent) else $error("absent id");
endmodule

bind eil_loader eil_loader_assertions #(.DEF_ID(DEF_ID)) u_chk (
  .clock(clock), .rst_b(rst_b), .link_clk(link_clk), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .id(id), .load_done(load_done),
  .eeprom_found(eeprom_found)
);
`default_nettype wire

//--- bench/eil_loader_tb.sv
// Testbench for the identity loader with an EEPROM model
`default_nettype none
module eil_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam eil_pkg::eil_id_t DEF = '{16'h1111, 16'h2222, 16'h3333,
                                       16'h4444, 8'h55};
  localparam eil_pkg::eil_id_t EXP = '{16'hb2a1, 16'hd4c3, 16'hf6e5,
                                       16'h1807, 8'h29};
  logic             clock = 1'b0;
  logic             link_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             present = 1'b1;
  logic             jam = 1'b0;
  logic [71:0]      image = 72'ha1b2c3d4e5f6071829;
  logic             scl_oe, sda_oe, scl_out, sda_out, pull;
  logic             load_done, eeprom_found, scl_w, sda_w;
  eil_pkg::eil_id_t id;
  int               mismatches = 0;
  int               check_count = 0;
  // Open-drain wires with pull-ups
  assign scl_w = !(scl_oe || jam);
  assign sda_w = !(sda_oe || pull);
  always #2.5 clock = ~clock;
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  eil_loader #(.IDLE_CNT(4), .DEF_ID(DEF)) DUT (
    .clock(clock), .rst_b(rst_b), .link_clk(link_clk), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .id(id), .load_done(load_done),
    .eeprom_found(eeprom_found)
  );
  eil_eeprom_model u_rom (
    .scl(scl_w), .sda(sda_w), .present(present), .image(image),
    .pull(pull)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Link domain needs three of its edges inside reset
  task automatic hold_reset();
    repeat (12) @(negedge clock);
    repeat (3) @(posedge link_clk);
    @(negedge clock);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (load_done !== 1'b1 && n < 70000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    hold_reset();
    chk("id in reset", DEF, id);
    chk("done in reset", 0, load_done);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    chk("id after reset", DEF, id);
    chk("found after reset", 0, eeprom_found);
    $display("test reset done");
  endtask
  task automatic test_present();
    wait_done();
    chk("done", 1, load_done);
    chk("id loaded", EXP, id);
    chk("found", 1, eeprom_found);
    $display("test present done");
  endtask
  task automatic test_hold();
    repeat (2000) @(negedge clock);
    chk("id held", EXP, id);
    chk("done held", 1, load_done);
    chk("bus free", 0, {scl_oe, sda_oe});
    chk("pin values low", 0, {scl_out, sda_out});
    $display("test hold done");
  endtask
  task automatic test_absent_busy();
    logic busy_oe;
    rst_b = 1'b0;
    present = 1'b0;
    jam = 1'b1;
    hold_reset();
    rst_b = 1'b1;
    // Any drive while the clock line is held low is a violation
    busy_oe = 1'b0;
    repeat (3000) begin
      @(negedge clock);
      busy_oe = busy_oe | scl_oe | sda_oe;
    end
    chk("no start on busy", 0, busy_oe);
    chk("not done on busy", 0, load_done);
    jam = 1'b0;
    wait_done();
    chk("absent done", 1, load_done);
    chk("absent id", DEF, id);
    chk("absent found", 0, eeprom_found);
    $display("test absent done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    test_reset();
    test_present();
    test_hold();
    test_absent_busy();
    print_verdict();
  end
  // Whole run is about 345 us; limit stays under 100k clocks
  initial begin
    #450000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
